// >>> design/dms_defs.vh
// Constants for the dial mode softswitch block
`ifndef DMS_DEFS_VH
`define DMS_DEFS_VH
`define DMS_CLK_KHZ        100000
`define DMS_DEBOUNCE_MS    32
`define DMS_PACIFIER_MS    75
`define DMS_DEBOUNCE_CYC   (`DMS_DEBOUNCE_MS * `DMS_CLK_KHZ)
`define DMS_PACIFIER_CYC   (`DMS_PACIFIER_MS * `DMS_CLK_KHZ)
`define DMS_MODE_PULSE     1'b0
`define DMS_MODE_TONE      1'b1
`define DMS_DEPTH          32
`define DMS_ADDR_W         5
`define DMS_ENTRY_W        5
`define DMS_SWITCH_CODE    5'h1F
`define DMS_CNT_W          24
`endif

// >>> design/dms_mem.v
// Redial buffer storage with registered read data
`include "dms_defs.vh"
`default_nettype none
module dms_mem #(
	parameter DEPTH  = `DMS_DEPTH,
	parameter ADDR_W = `DMS_ADDR_W,
	parameter DATA_W = `DMS_ENTRY_W
) (
	// Clock
	input  wire              core_clk,
	// Write side
	input  wire              wr_en,
	input  wire [ADDR_W-1:0] wr_addr,
	input  wire [DATA_W-1:0] wr_data,
	// Read side
	input  wire [ADDR_W-1:0] rd_addr,
	output reg  [DATA_W-1:0] rd_data
);
	reg [DATA_W-1:0] mem [0:DEPTH-1];

	// Write port and registered read port
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // dms_mem
`default_nettype wire

// >>> design/dms_softswitch.v
// Dial mode control with softswitch recording, mixed redial and pacifier tone
`include "dms_defs.vh"
`default_nettype none
// Function
// - Pulse-to-tone change while pulse dialing selects tone
// - Record softswitch entry in redial buffer
// - Mixed redial only when mode reads pulse
// - Later tone-to-pulse returns pulse, not recorded
// - Tone-start dialing: tone-to-pulse applies, unrecorded
// - Redial in tone sends all digits tone
// - Debounce 32ms, then pacifier tone 75ms on a change to tone
// - Pulse redial: pulse until softswitch, then tone
// - Hookswitch transition reinitializes, mode from input
module dms_softswitch #(
	parameter DEBOUNCE_CYC = `DMS_DEBOUNCE_CYC,
	parameter PACIFIER_CYC = `DMS_PACIFIER_CYC
) (
	// Clock and reset
	input  wire       core_clk,
	input  wire       sys_rst,
	// Pins from switches (asynchronous)
	input  wire       mode_select,
	input  wire       hookswitch_input,
	// Keypad digit strobe from the key scanner
	input  wire       digit_valid,
	input  wire [3:0] digit_code,
	input  wire       last_number_redial,
	// Line signalling path
	input  wire       signal_ready,
	output reg        digit_send,
	output reg  [3:0] digit_out,
	output reg        digit_tone,
	output reg        signal_mode,
	output reg        pacifier_tone,
	output reg        redial_busy
);
	localparam ST_IDLE = 2'b00;
	localparam ST_READ = 2'b01;
	localparam ST_WAIT = 2'b10;
	localparam ST_SEND = 2'b11;

	reg                   mode_s1, mode_s2, hook_s1, hook_s2, hook_q;
	reg                   mode_deb;
	reg [`DMS_CNT_W-1:0]  deb_cnt;
	reg [`DMS_CNT_W-1:0]  pac_cnt;
	reg                   pulse_start;
	reg                   dialed;      // An entry was stored since going off-hook
	reg [`DMS_ADDR_W-1:0] wr_ptr;
	reg [`DMS_ADDR_W:0]   len;
	reg [`DMS_ADDR_W:0]   rd_idx;
	reg [1:0]             state;
	reg                   replay_tone;
	reg                   mem_we;
	reg [`DMS_ENTRY_W-1:0] mem_wd;
	wire [`DMS_ENTRY_W-1:0] mem_rd;
	wire                  hook_edge;
	wire                  mode_change;
	wire                  to_tone;

	// Softswitch marker decode, used by recording and replay
	function is_switch;
		input [`DMS_ENTRY_W-1:0] e;
		begin
			is_switch = (e == `DMS_SWITCH_CODE);
		end
	endfunction

	assign hook_edge   = hook_s2 ^ hook_q;
	assign mode_change = (deb_cnt == DEBOUNCE_CYC[`DMS_CNT_W-1:0]) && (mode_s2 != mode_deb);
	assign to_tone     = mode_change && (mode_s2 == `DMS_MODE_TONE);

	////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for both pins
	always @(posedge core_clk) begin
		if (sys_rst) begin
			mode_s1 <= 1'b0;
			mode_s2 <= 1'b0;
			hook_s1 <= 1'b1;
			hook_s2 <= 1'b1;
			hook_q  <= 1'b1;
		end else begin
			mode_s1 <= mode_select;
			mode_s2 <= mode_s1;
			hook_s1 <= hookswitch_input;
			hook_s2 <= hook_s1;
			hook_q  <= hook_s2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Debounce the mode level and time the pacifier tone
	always @(posedge core_clk) begin
		if (sys_rst) begin
			mode_deb      <= `DMS_MODE_PULSE;
			deb_cnt       <= {`DMS_CNT_W{1'b0}};
			pac_cnt       <= {`DMS_CNT_W{1'b0}};
			pacifier_tone <= 1'b0;
		end else if (hook_edge) begin
			mode_deb      <= mode_s2;
			deb_cnt       <= {`DMS_CNT_W{1'b0}};
			pac_cnt       <= {`DMS_CNT_W{1'b0}};
			pacifier_tone <= 1'b0;
		end else begin
			if (mode_s2 == mode_deb) begin
				deb_cnt <= {`DMS_CNT_W{1'b0}};
			end else if (mode_change) begin
				mode_deb <= mode_s2;
				deb_cnt  <= {`DMS_CNT_W{1'b0}};
			end else begin
				deb_cnt <= deb_cnt + 1'b1;
			end
			if (to_tone && !hook_s2) begin
				pacifier_tone <= 1'b1;
				pac_cnt       <= PACIFIER_CYC[`DMS_CNT_W-1:0];
			end else if (pac_cnt != {`DMS_CNT_W{1'b0}}) begin
				pac_cnt <= pac_cnt - 1'b1;
				if (pac_cnt == {{(`DMS_CNT_W-1){1'b0}}, 1'b1}) begin
					pacifier_tone <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Redial buffer
	dms_mem #(
		.DEPTH  (`DMS_DEPTH),
		.ADDR_W (`DMS_ADDR_W),
		.DATA_W (`DMS_ENTRY_W)
	) u_mem (
		.core_clk (core_clk),
		.wr_en    (mem_we),
		.wr_addr  (wr_ptr),
		.wr_data  (mem_wd),
		.rd_addr  (rd_idx[`DMS_ADDR_W-1:0]),
		.rd_data  (mem_rd)
	);

	// Write request: digits when dialing, softswitch marker on pulse-to-tone
	always @* begin
		mem_we = 1'b0;
		mem_wd = {1'b0, digit_code};
		if (!hook_s2 && state == ST_IDLE) begin
			if (to_tone && pulse_start && signal_mode == `DMS_MODE_PULSE
					&& dialed) begin
				mem_we = 1'b1;
				mem_wd = `DMS_SWITCH_CODE;
			end else if (digit_valid) begin
				mem_we = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode control, recording and replay sequencer
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state       <= ST_IDLE;
			wr_ptr      <= {`DMS_ADDR_W{1'b0}};
			len         <= {(`DMS_ADDR_W+1){1'b0}};
			rd_idx      <= {(`DMS_ADDR_W+1){1'b0}};
			signal_mode <= `DMS_MODE_PULSE;
			pulse_start <= 1'b1;
			dialed      <= 1'b0;
			replay_tone <= 1'b0;
			digit_send  <= 1'b0;
			digit_out   <= 4'h0;
			digit_tone  <= 1'b0;
			redial_busy <= 1'b0;
		end else if (hook_edge) begin
			state       <= ST_IDLE;
			signal_mode <= mode_s2;
			pulse_start <= (mode_s2 == `DMS_MODE_PULSE);
			digit_send  <= 1'b0;
			redial_busy <= 1'b0;
			if (!hook_s2) begin
				wr_ptr <= {`DMS_ADDR_W{1'b0}};
				rd_idx <= {(`DMS_ADDR_W+1){1'b0}};
				dialed <= 1'b0; // Old buffer stays for redial until a new entry lands
			end
		end else begin
			digit_send <= 1'b0;
			if (mode_change) begin
				signal_mode <= mode_s2;
			end
			case (state)
			ST_IDLE: begin
				if (mem_we) begin
					dialed <= 1'b1;
					// First entry of a call restarts the length; a wrap does not
					if (!dialed) begin
						len <= {{`DMS_ADDR_W{1'b0}}, 1'b1};
					end else if (len != `DMS_DEPTH) begin
						len <= len + 1'b1;
					end
					wr_ptr <= wr_ptr + 1'b1;
					if (!is_switch(mem_wd)) begin
						digit_send <= 1'b1;
						digit_out  <= digit_code;
						digit_tone <= signal_mode;
					end
				end else if (!hook_s2 && last_number_redial && len != 0) begin
					replay_tone <= (mode_s2 == `DMS_MODE_TONE);
					rd_idx      <= {(`DMS_ADDR_W+1){1'b0}};
					redial_busy <= 1'b1;
					state       <= ST_READ;
				end
			end
			ST_READ: begin
				state <= ST_WAIT;
			end
			ST_WAIT: begin
				if (is_switch(mem_rd)) begin
					replay_tone <= 1'b1;
					signal_mode <= `DMS_MODE_TONE;
					state       <= ST_SEND;
				end else if (signal_ready) begin
					digit_send <= 1'b1;
					digit_out  <= mem_rd[3:0];
					digit_tone <= replay_tone;
					state      <= ST_SEND;
				end
			end
			ST_SEND: begin
				if (rd_idx + 1'b1 >= len) begin
					redial_busy <= 1'b0;
					state       <= ST_IDLE;
				end else begin
					rd_idx <= rd_idx + 1'b1;
					state  <= ST_READ;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // dms_softswitch
`default_nettype wire

// >>> tb/dms_softswitch_props.sv
// Port assertions for the dial mode softswitch
`default_nettype none
module dms_props #(parameter DEBOUNCE_CYC = 20, PACIFIER_CYC = 30) (
	// Clock, reset, pins and keypad
	input wire logic       core_clk, sys_rst, mode_select, hookswitch_input, digit_valid,
	input wire logic [3:0] digit_code, digit_out,
	// Line side and status
	input wire logic       last_number_redial, signal_ready, digit_send, digit_tone,
	input wire logic       signal_mode, pacifier_tone, redial_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] pc;
	logic        tseen;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Pacifier length, and tone already seen in this replay
	always_ff @(posedge core_clk) begin
		pc    <= pacifier_tone ? pc + 24'h1 : 24'h0;
		tseen <= redial_busy && (tseen || (digit_send && digit_tone));
	end
	AST_PAC_MODE: assert property ($rose(pacifier_tone) |-> $rose(signal_mode))
		else $error("pacifier without mode switch");
	AST_PAC_MAX: assert property (pacifier_tone |-> pc < PACIFIER_CYC)
		else $error("pacifier too long");
	AST_LIVE: assert property (!hookswitch_input [*6] ##0 digit_valid && !redial_busy
		|=> digit_send && digit_out == $past(digit_code) && digit_tone == $past(signal_mode))
		else $error("live digit wrong");
	AST_TONE_HOLD: assert property (digit_send && redial_busy && tseen |-> digit_tone)
		else $error("pulse after tone in replay");
	AST_MODE_SRC: assert property ($changed(signal_mode) |->
		signal_mode == $past(mode_select, 3) || (redial_busy && signal_mode == 1'b1))
		else $error("mode not from pin");
	AST_HOOK_ABORT: assert property ($changed(hookswitch_input) |-> ##4 !redial_busy)
		else $error("replay not aborted");
	AST_ONHOOK_QUIET: assert property (hookswitch_input [*6] |-> !digit_send)
		else $error("digit sent on hook");
	AST_REPLAY_GAP: assert property (digit_send && redial_busy |=> !digit_send)
		else $error("replay sends too close");
	// Main scenarios
	cover property ($fell(pacifier_tone));
	cover property (digit_send && redial_busy && !digit_tone);
	cover property (digit_send && redial_busy && digit_tone);
endmodule // dms_props
bind dms_softswitch dms_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .PACIFIER_CYC(PACIFIER_CYC)) u_dms_props (
	.core_clk, .sys_rst, .mode_select, .hookswitch_input, .digit_valid, .digit_code, .digit_out,
	.last_number_redial, .signal_ready, .digit_send, .digit_tone, .signal_mode, .pacifier_tone,
	.redial_busy);
`default_nettype wire

// >>> tb/dms_line_model.sv
// Line signalling path that paces replayed digits
`default_nettype none
module dms_line_model (
	// Clock, pacing choice, digit strobe
	input  wire logic core_clk, slow, digit_send,
	// Ready towards the dialer
	output wire logic signal_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int busy = 0;
	// Busy while a digit is being signalled, longer when slow
	always @(posedge core_clk) begin
		if (digit_send) busy <= slow ? 9 : 1;
		else if (busy > 0) busy <= busy - 1;
	end
	assign signal_ready = (busy == 0);
endmodule // dms_line_model
`default_nettype wire

// >>> tb/dms_softswitch_bench.sv
// Self-checking bench for the dial mode softswitch
`default_nettype none
module dms_softswitch_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEB = 20, PAC = 30;
	logic core_clk = 0, sys_rst = 1, mode_select = 0, hookswitch_input = 1, mt = 0;
	logic digit_valid = 0, last_number_redial = 0, slow = 0, signal_ready;
	logic [3:0] digit_code = 4'h0, digit_out;
	logic digit_send, digit_tone, signal_mode, pacifier_tone, redial_busy;
	int error_cnt = 0, num_checks = 0, ps = 0, fresh = 1, q[$];
	dms_softswitch #(.DEBOUNCE_CYC(DEB), .PACIFIER_CYC(PAC)) u_dms_softswitch (
		.core_clk, .sys_rst, .mode_select, .hookswitch_input, .digit_valid, .digit_code,
		.last_number_redial, .signal_ready, .digit_send, .digit_out, .digit_tone,
		.signal_mode, .pacifier_tone, .redial_busy);
	dms_line_model u_dms_line_model (.core_clk, .slow, .digit_send, .signal_ready);
	initial forever #5 core_clk = ~core_clk;
	task automatic chk(input string s, input logic [7:0] v, e);
		num_checks++;
		if (v !== e) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", s, e, v);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Live digit: model stores it, line shows it one cycle on
	task automatic dial(input logic [3:0] d);
		if (fresh) begin q.delete(); ps = !mt; end
		fresh = 0;
		q.push_back(d);
		digit_valid <= 1;
		digit_code <= d;
		@(posedge core_clk) digit_valid <= 0;
		repeat (3) begin @(negedge core_clk); if (digit_send === 1'b1) break; end
		chk("send", digit_send, 1);
		chk("digit", {digit_tone, digit_out}, {mt, d});
		@(posedge core_clk);
	endtask
	// Mode pin change off hook; marker only on pulse start
	task automatic setmode(input logic m);
		int n = 0;
		if (m && !mt && ps && !fresh) q.push_back(-1);
		mode_select <= m;
		repeat (DEB + PAC + 20) begin @(negedge core_clk); n += pacifier_tone; end
		chk("pacifier", n, (m && !mt) ? PAC : 0);
		mt = m;
		chk("mode", signal_mode, m);
		@(posedge core_clk);
	endtask
	// Hook cycle with the pin set while on hook
	task automatic hook(input logic m);
		hookswitch_input <= 1;
		mode_select <= m;
		repeat (DEB + PAC + 20) @(posedge core_clk);
		hookswitch_input <= 0;
		repeat (10) @(posedge core_clk);
		fresh = 1;
		mt = m;
		chk("hookmode", signal_mode, m);
	endtask
	// Replay against the model buffer
	task automatic redial;
		int t = mt, k = 0;
		last_number_redial <= 1;
		@(posedge core_clk) last_number_redial <= 0;
		repeat (400) begin
			@(negedge core_clk);
			if (digit_send === 1'b1) begin
				while (k < q.size() && q[k] < 0) begin k++; t = 1; end
				chk("replay", {digit_tone, digit_out}, {t[0], 4'(q[k])});
				chk("busy", redial_busy, 1);
				k++;
			end
		end
		chk("count", k, q.size());
		chk("idle", redial_busy, 0);
		@(posedge core_clk);
	endtask
	initial begin
		void'($urandom(29430));
		repeat (3) @(posedge core_clk);
		sys_rst <= 0;
		hook(0);
		repeat (3) dial(4'($urandom % 10));
		setmode(1);
		repeat (2) dial(4'($urandom % 10));
		setmode(0);
		hook(0);
		slow <= 1;
		redial();
		hook(1);
		redial();
		slow <= 0;
		repeat (2) dial(4'($urandom % 10));
		setmode(0);
		dial(4'($urandom % 10));
		hook(0);
		redial();
		// Going on-hook in mid-replay aborts it
		slow <= 1;
		last_number_redial <= 1;
		@(posedge core_clk) last_number_redial <= 0;
		repeat (5) @(posedge core_clk);
		chk("busy", redial_busy, 1);
		hookswitch_input <= 1;
		repeat (5) @(posedge core_clk);
		chk("abort", redial_busy, 0);
		test_done();
	end
endmodule // dms_softswitch_bench
`default_nettype wire
